// ===== rtl/cnd_pkg.sv
package cnd_pkg;
   // identifier field width, standard format only
   localparam int ID_W = 11;
   localparam int NODE_W = 7;
   localparam int PLD_W = 64;
   localparam int DLC_W = 4;

   // default identifier map, function codes before node number is added
   localparam logic [10:0] ID_NMT      = 11'h000;
   localparam logic [10:0] ID_SYNC     = 11'h080;
   localparam logic [10:0] ID_EMCY     = 11'h080;
   localparam logic [10:0] ID_TPDO1    = 11'h180;
   localparam logic [10:0] ID_RPDO1    = 11'h200;
   localparam logic [10:0] ID_TPDO2    = 11'h280;
   localparam logic [10:0] ID_RPDO2    = 11'h300;
   localparam logic [10:0] ID_TPDO3    = 11'h380;
   localparam logic [10:0] ID_RPDO3    = 11'h400;
   localparam logic [10:0] ID_TPDO4    = 11'h480;
   localparam logic [10:0] ID_RPDO4    = 11'h500;
   localparam logic [10:0] ID_SDO_TX   = 11'h580;
   localparam logic [10:0] ID_SDO_RX   = 11'h600;
   localparam logic [10:0] ID_NODEMON  = 11'h700;

   localparam logic [3:0] NMT_DLC = 4'h2;
   localparam logic [6:0] NODE_BCAST = 7'h00;
   localparam logic [6:0] NODE_MIN = 7'h01;
   localparam logic [6:0] NODE_MAX = 7'h7f;

   // command byte codes
   localparam logic [7:0] CMD_START    = 8'h01;
   localparam logic [7:0] CMD_STOP     = 8'h02;
   localparam logic [7:0] CMD_PREOP    = 8'h80;
   localparam logic [7:0] CMD_RST_NODE = 8'h81;
   localparam logic [7:0] CMD_RST_COMM = 8'h82;

   // init phase length in cycles
   localparam int INIT_CYC = 4;
   localparam int INIT_W = 3;

   typedef enum logic [1:0]
   {
      ST_INIT  = 2'b00,
      ST_PREOP = 2'b01,
      ST_OPER  = 2'b10,
      ST_STOP  = 2'b11
   } cnd_state_t;

   typedef enum logic [3:0]
   {
      SV_NONE  = 4'h0,
      SV_NMT   = 4'h1,
      SV_SYNC  = 4'h2,
      SV_EMCY  = 4'h3,
      SV_TPDO  = 4'h4,
      SV_RPDO  = 4'h5,
      SV_SDOTX = 4'h6,
      SV_SDORX = 4'h7,
      SV_NODEM = 4'h8
   } cnd_svc_t;

   typedef struct packed
   {
      logic [10:0] id;
      logic        ext;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;
   } cnd_frame_t;

   typedef struct packed
   {
      logic pdo;
      logic sdo;
      logic sync;
      logic emcy;
      logic boot;
      logic nmt;
   } cnd_gate_t;

   // byte k of payload, byte 0 is first on the wire (lsb first)
   function automatic logic [7:0] cnd_byte(input logic [63:0] d,
                                           input int k);
      cnd_byte = d[k*8 +: 8];
   endfunction

   function automatic logic [10:0] cnd_id(input logic [10:0] base,
                                          input logic [6:0] node);
      cnd_id = base + {4'h0, node};
   endfunction
endpackage

// ===== rtl/cnd_classify.sv
`timescale 1ns/1ns
`default_nettype none
module cnd_classify
(
   input  wire cnd_pkg::cnd_frame_t frame,
   input  wire logic [6:0]          node_id,
   input  wire logic                is_tx,
   output cnd_pkg::cnd_svc_t        svc,
   output logic [1:0]               pdo_ch
);
   import cnd_pkg::*;

   always_comb
   begin
      svc = SV_NONE;
      pdo_ch = 2'd0;
      if (frame.ext)
      begin
         svc = SV_NONE;
      end
      else if (!is_tx)
      begin
         if (frame.id == ID_NMT)
            svc = SV_NMT;
         else if (frame.id == ID_SYNC)
            svc = SV_SYNC;
         else if (frame.id == cnd_id(ID_SDO_RX, node_id))
            svc = SV_SDORX;
         else if (frame.id == cnd_id(ID_NODEMON, node_id))
            svc = SV_NODEM;
         else if (frame.id == cnd_id(ID_RPDO1, node_id))
         begin
            svc = SV_RPDO;
            pdo_ch = 2'd0;
         end
         else if (frame.id == cnd_id(ID_RPDO2, node_id))
         begin
            svc = SV_RPDO;
            pdo_ch = 2'd1;
         end
         else if (frame.id == cnd_id(ID_RPDO3, node_id))
         begin
            svc = SV_RPDO;
            pdo_ch = 2'd2;
         end
         else if (frame.id == cnd_id(ID_RPDO4, node_id))
         begin
            svc = SV_RPDO;
            pdo_ch = 2'd3;
         end
      end
      else
      begin
         if (frame.id == cnd_id(ID_EMCY, node_id))
            svc = SV_EMCY;
         else if (frame.id == cnd_id(ID_SDO_TX, node_id))
            svc = SV_SDOTX;
         else if (frame.id == cnd_id(ID_NODEMON, node_id))
            svc = SV_NODEM;
         else if (frame.id == cnd_id(ID_TPDO1, node_id))
         begin
            svc = SV_TPDO;
            pdo_ch = 2'd0;
         end
         else if (frame.id == cnd_id(ID_TPDO2, node_id))
         begin
            svc = SV_TPDO;
            pdo_ch = 2'd1;
         end
         else if (frame.id == cnd_id(ID_TPDO3, node_id))
         begin
            svc = SV_TPDO;
            pdo_ch = 2'd2;
         end
         else if (frame.id == cnd_id(ID_TPDO4, node_id))
         begin
            svc = SV_TPDO;
            pdo_ch = 2'd3;
         end
      end
   end
endmodule // cnd_classify
`default_nettype wire

// ===== rtl/cnd_gate.sv
`timescale 1ns/1ns
`default_nettype none
module cnd_gate
(
   input  wire cnd_pkg::cnd_state_t state,
   output cnd_pkg::cnd_gate_t       gate
);
   import cnd_pkg::*;

   always_comb
   begin
      gate.pdo  = (state == ST_OPER);
      gate.sdo  = (state == ST_PREOP) || (state == ST_OPER);
      gate.sync = (state == ST_PREOP) || (state == ST_OPER);
      gate.emcy = (state == ST_PREOP) || (state == ST_OPER);
      gate.boot = (state == ST_INIT);
      // stopped keeps only management alive
      gate.nmt  = (state != ST_INIT);
   end
endmodule // cnd_gate
`default_nettype wire

// ===== rtl/cnd_nmt_slave.sv
`timescale 1ns/1ns
`default_nettype none
module cnd_nmt_slave
(
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire logic [6:0]          node_id_cfg,
   input  wire logic                rx_valid,
   input  wire cnd_pkg::cnd_frame_t rx_frame,
   input  wire logic                tx_req,
   input  wire cnd_pkg::cnd_frame_t tx_frame,
   output logic                     tx_grant,
   output logic                     rx_deliver,
   output cnd_pkg::cnd_svc_t        rx_svc_reg,
   output logic [1:0]               rx_pdo_ch_reg,
   output cnd_pkg::cnd_frame_t      rx_frame_reg,
   output cnd_pkg::cnd_state_t      state_reg,
   output cnd_pkg::cnd_gate_t       gate,
   output logic [6:0]               node_id_reg,
   output logic                     node_reset_reg,
   output logic                     comm_reset_reg,
   output logic                     boot_send_reg,
   output cnd_pkg::cnd_frame_t      boot_frame_reg
);
   import cnd_pkg::*;

   cnd_svc_t            rx_svc;
   cnd_svc_t            tx_svc;
   logic [1:0]          rx_ch;
   cnd_state_t          state_next;
   logic [INIT_W-1:0]   init_cnt_reg;
   logic [INIT_W-1:0]   init_cnt_next;
   logic [6:0]          node_id_next;
   logic                node_reset_next;
   logic                comm_reset_next;
   logic                boot_send_next;
   cnd_frame_t          boot_frame_next;
   logic                rx_deliver_next;
   logic                rx_deliver_reg;
   cnd_svc_t            rx_svc_next;
   logic [1:0]          rx_pdo_ch_next;
   cnd_frame_t          rx_frame_next;
   logic [7:0]          cmd_byte;
   logic [7:0]          tgt_byte;
   logic                nmt_hit;
   logic                node_ok;
   logic                cmd_ok;

   cnd_classify u_rx_cls
   (
      .frame   (rx_frame),
      .node_id (node_id_reg),
      .is_tx   (1'b0),
      .svc     (rx_svc),
      .pdo_ch  (rx_ch)
   );

   cnd_classify u_tx_cls
   (
      .frame   (tx_frame),
      .node_id (node_id_reg),
      .is_tx   (1'b1),
      .svc     (tx_svc),
      .pdo_ch  ()
   );

   cnd_gate u_gate
   (
      .state (state_reg),
      .gate  (gate)
   );

   // payload byte order: command is byte 0, target byte 1
   assign cmd_byte = cnd_byte(rx_frame.data, 0);
   assign tgt_byte = cnd_byte(rx_frame.data, 1);

   // a bad strap falls back to node 1 rather than a broadcast id
   assign node_ok = (node_id_cfg >= NODE_MIN)
                    && (node_id_cfg <= NODE_MAX);

   // addressed management frame, exactly two bytes
   assign nmt_hit = rx_valid && (rx_svc == SV_NMT) && gate.nmt
                    && !rx_frame.rtr && (rx_frame.dlc == NMT_DLC)
                    && ((tgt_byte == {1'b0, NODE_BCAST})
                        || (tgt_byte == {1'b0, node_id_reg}));

   // codes outside the defined set are dropped, not delivered
   assign cmd_ok = (cmd_byte == CMD_START) || (cmd_byte == CMD_STOP)
                   || (cmd_byte == CMD_PREOP) || (cmd_byte == CMD_RST_NODE)
                   || (cmd_byte == CMD_RST_COMM);

   always_comb
   begin
      state_next = state_reg;
      init_cnt_next = init_cnt_reg;
      node_id_next = node_id_reg;
      node_reset_next = 1'b0;
      comm_reset_next = 1'b0;
      boot_send_next = 1'b0;
      boot_frame_next = boot_frame_reg;
      unique case (state_reg)
         ST_INIT:
         begin
            if (init_cnt_reg == INIT_W'(INIT_CYC - 1))
            begin
               // bus settings reloaded here, then boot-up announced
               node_id_next = node_ok ? node_id_cfg : NODE_MIN;
               boot_send_next = 1'b1;
               boot_frame_next = '0;
               boot_frame_next.id = cnd_id(ID_NODEMON,
                                           node_ok ? node_id_cfg
                                                   : NODE_MIN);
               boot_frame_next.dlc = 4'h1;
               state_next = ST_PREOP;
               init_cnt_next = '0;
            end
            else
               init_cnt_next = init_cnt_reg + INIT_W'(1);
         end
         ST_PREOP, ST_OPER, ST_STOP:
         begin
            if (nmt_hit)
            begin
               // same-state requests fall through as no change
               unique case (cmd_byte)
                  CMD_START: state_next = ST_OPER;
                  CMD_STOP: state_next = ST_STOP;
                  CMD_PREOP: state_next = ST_PREOP;
                  CMD_RST_NODE:
                  begin
                     state_next = ST_INIT;
                     node_reset_next = 1'b1;
                  end
                  CMD_RST_COMM:
                  begin
                     state_next = ST_INIT;
                     comm_reset_next = 1'b1;
                  end
                  default: state_next = state_reg;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state_reg <= ST_INIT;
         init_cnt_reg <= '0;
         node_id_reg <= NODE_MIN;
         node_reset_reg <= 1'b0;
         comm_reset_reg <= 1'b0;
         boot_send_reg <= 1'b0;
         boot_frame_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         init_cnt_reg <= init_cnt_next;
         node_id_reg <= node_id_next;
         node_reset_reg <= node_reset_next;
         comm_reset_reg <= comm_reset_next;
         boot_send_reg <= boot_send_next;
         boot_frame_reg <= boot_frame_next;
      end
   end

   // receive side: deliver a frame only if its service runs now
   always_comb
   begin
      rx_deliver_next = 1'b0;
      rx_svc_next = rx_svc_reg;
      rx_pdo_ch_next = rx_pdo_ch_reg;
      rx_frame_next = rx_frame_reg;
      if (rx_valid)
      begin
         unique case (rx_svc)
            SV_RPDO: rx_deliver_next = gate.pdo;
            SV_SDORX: rx_deliver_next = gate.sdo;
            SV_SYNC: rx_deliver_next = gate.sync;
            SV_NODEM: rx_deliver_next = gate.nmt && !gate.boot;
            SV_NMT: rx_deliver_next = nmt_hit && cmd_ok;
            default: rx_deliver_next = 1'b0;
         endcase
         if (rx_deliver_next)
         begin
            rx_svc_next = rx_svc;
            rx_pdo_ch_next = rx_ch;
            rx_frame_next = rx_frame;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         rx_deliver_reg <= 1'b0;
         rx_svc_reg <= SV_NONE;
         rx_pdo_ch_reg <= 2'd0;
         rx_frame_reg <= '0;
      end
      else
      begin
         rx_deliver_reg <= rx_deliver_next;
         rx_svc_reg <= rx_svc_next;
         rx_pdo_ch_reg <= rx_pdo_ch_next;
         rx_frame_reg <= rx_frame_next;
      end
   end

   assign rx_deliver = rx_deliver_reg;

   // transmit side: combinational grant, extended never allowed
   always_comb
   begin
      tx_grant = 1'b0;
      if (tx_req && !tx_frame.ext)
      begin
         unique case (tx_svc)
            SV_TPDO: tx_grant = gate.pdo;
            SV_SDOTX: tx_grant = gate.sdo;
            SV_EMCY: tx_grant = gate.emcy;
            // heartbeat falls silent in stopped too; boot-up has its own path
            SV_NODEM: tx_grant = (state_reg == ST_PREOP)
                                 || (state_reg == ST_OPER);
            default: tx_grant = 1'b0;
         endcase
      end
   end

   // one init run: four cycles in initialising, then the boot-up pulse
   sequence s_init_run;
      state_reg == ST_INIT ##4 boot_send_reg;
   endsequence

   a_boot_to_preop: assert property
      (@(posedge ref_clk) disable iff (srst)
       boot_send_reg |-> state_reg == ST_PREOP
                         && $past(state_reg) == ST_INIT)
      else $error("boot-up not paired with move to preop");

   a_init_entry: assert property
      (@(posedge ref_clk) disable iff (srst)
       (state_reg == ST_INIT && $past(state_reg) != ST_INIT)
       |-> node_reset_reg || comm_reset_reg)
      else $error("init entered without reset command");

   a_init_length: assert property
      (@(posedge ref_clk) disable iff (srst)
       $rose(comm_reset_reg) |-> s_init_run)
      else $error("init phase wrong length");

   a_node_restart: assert property
      (@(posedge ref_clk) disable iff (srst)
       $rose(node_reset_reg) |-> s_init_run)
      else $error("node restart skipped initialisation");

   a_stop_quiet: assert property
      (@(posedge ref_clk) disable iff (srst)
       state_reg == ST_STOP |-> !tx_grant)
      else $error("transmit granted while stopped");

   a_pdo_oper: assert property
      (@(posedge ref_clk) disable iff (srst)
       (rx_deliver && rx_svc_reg == SV_RPDO)
       |-> $past(state_reg) == ST_OPER)
      else $error("process data outside operational");

   a_ext_block: assert property
      (@(posedge ref_clk) disable iff (srst)
       tx_req && tx_frame.ext |-> !tx_grant)
      else $error("extended frame granted");

   a_start_cmd: assert property
      (@(posedge ref_clk) disable iff (srst)
       nmt_hit && cmd_byte == CMD_START |=> state_reg == ST_OPER)
      else $error("start not obeyed");

   a_foreign_node: assert property
      (@(posedge ref_clk) disable iff (srst)
       (rx_valid && rx_svc == SV_NMT && tgt_byte != 8'h00
        && tgt_byte != {1'b0, node_id_reg} && state_reg != ST_INIT)
       |=> $stable(state_reg))
      else $error("foreign node command obeyed");

   a_bad_cmd: assert property
      (@(posedge ref_clk) disable iff (srst)
       (nmt_hit && cmd_byte != CMD_START && cmd_byte != CMD_STOP
        && cmd_byte != CMD_PREOP && cmd_byte != CMD_RST_NODE
        && cmd_byte != CMD_RST_COMM)
       |=> $stable(state_reg) && !rx_deliver)
      else $error("unknown command changed state or was delivered");

   a_node_range: assert property
      (@(posedge ref_clk) disable iff (srst)
       node_id_reg != 7'h00)
      else $error("node number out of range");
endmodule // cnd_nmt_slave
`default_nettype wire

// ===== sim/cnd_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module cnd_master_model
(
   input  wire logic          ref_clk,
   output cnd_pkg::cnd_frame_t rx_frame,
   output logic               rx_valid
);
   import cnd_pkg::*;

   initial
   begin
      rx_valid = 1'b0;
      rx_frame = '0;
   end

   // one frame per call; a released bus shows the inverse so stale data
   // never passes for a fresh frame
   task automatic send(input logic [10:0] id, input logic ext,
                       input logic [3:0] dlc, input logic [63:0] data);
      @(negedge ref_clk);
      rx_frame = '{id: id, ext: ext, rtr: 1'b0, dlc: dlc, data: data};
      rx_valid = 1'b1;
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_frame = ~rx_frame;
   endtask

   // command code in byte 0, target node in byte 1
   task automatic nmt(input logic [7:0] cmd, input logic [7:0] node);
      send(ID_NMT, 1'b0, NMT_DLC, {48'h0000_0000_0000, node, cmd});
   endtask
endmodule // cnd_master_model
`default_nettype wire

// ===== sim/cnd_nmt_slave_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) \
   begin \
      checks++; \
      if ((a) !== (b)) \
      begin \
         error_cnt++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
      end \
   end
module cnd_nmt_slave_tb;
   import cnd_pkg::*;

   localparam logic [10:0] N   = 11'h005;
   localparam logic [63:0] PLD = 64'h8877_6655_4433_0001;

   logic        ref_clk = 1'b0;
   logic        srst;
   logic [6:0]  node_id_cfg;
   logic        rx_valid;
   cnd_frame_t  rx_frame;
   logic        tx_req;
   cnd_frame_t  tx_frame;
   logic        tx_grant;
   logic        rx_deliver;
   cnd_svc_t    rx_svc_reg;
   logic [1:0]  rx_pdo_ch_reg;
   cnd_frame_t  rx_frame_reg;
   cnd_state_t  state_reg;
   cnd_gate_t   gate;
   logic [6:0]  node_id_reg;
   logic        node_reset_reg;
   logic        comm_reset_reg;
   logic        boot_send_reg;
   cnd_frame_t  boot_frame_reg;
   int          error_cnt = 0;
   int          checks = 0;

   always #5 ref_clk = ~ref_clk;

   cnd_master_model master
   (
      .ref_clk  (ref_clk),
      .rx_frame (rx_frame),
      .rx_valid (rx_valid)
   );

   cnd_nmt_slave dut
   (
      .ref_clk        (ref_clk),
      .srst           (srst),
      .node_id_cfg    (node_id_cfg),
      .rx_valid       (rx_valid),
      .rx_frame       (rx_frame),
      .tx_req         (tx_req),
      .tx_frame       (tx_frame),
      .tx_grant       (tx_grant),
      .rx_deliver     (rx_deliver),
      .rx_svc_reg     (rx_svc_reg),
      .rx_pdo_ch_reg  (rx_pdo_ch_reg),
      .rx_frame_reg   (rx_frame_reg),
      .state_reg      (state_reg),
      .gate           (gate),
      .node_id_reg    (node_id_reg),
      .node_reset_reg (node_reset_reg),
      .comm_reset_reg (comm_reset_reg),
      .boot_send_reg  (boot_send_reg),
      .boot_frame_reg (boot_frame_reg)
   );

   task automatic close_out;
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   function automatic cnd_gate_t exp_gate(input cnd_state_t s);
      logic c;
      c = (s == ST_PREOP) || (s == ST_OPER);
      exp_gate = '{pdo: s == ST_OPER, sdo: c, sync: c, emcy: c,
                   boot: s == ST_INIT, nmt: s != ST_INIT};
   endfunction

   // state must sit in init until the boot pulse, then land in preop
   task automatic wait_boot(input logic [6:0] node, output int n);
      n = 0;
      while (boot_send_reg !== 1'b1 && n < 20)
      begin
         `CHK(state_reg, ST_INIT)
         @(negedge ref_clk);
         #1;
         n++;
      end
      `CHK(state_reg, ST_PREOP)
      `CHK(node_id_reg, node)
      `CHK(boot_frame_reg.id, ID_NODEMON + {4'h0, node})
      `CHK(boot_frame_reg.dlc, 4'h1)
      `CHK(boot_frame_reg.data, 64'h0000_0000_0000_0000)
      `CHK(node_reset_reg | comm_reset_reg, 1'b0)
   endtask

   task automatic step(input logic [7:0] cmd, input logic [7:0] node,
                       input logic dlv, input cnd_state_t st);
      master.nmt(cmd, node);
      #1;
      `CHK(rx_deliver, dlv)
      `CHK(state_reg, st)
      `CHK(gate, exp_gate(st))
   endtask

   task automatic rx(input logic [10:0] id, input logic ext, input logic dlv,
                     input cnd_svc_t sv, input logic [1:0] ch);
      master.send(id, ext, 4'h8, PLD);
      #1;
      `CHK(rx_deliver, dlv)
      if (dlv)
      begin
         `CHK(rx_svc_reg, sv)
         `CHK(rx_frame_reg.data, PLD)
         if (sv == SV_RPDO)
            `CHK(rx_pdo_ch_reg, ch)
      end
   endtask

   // grant is combinational, so it is judged in the cycle it is asked;
   // the request stands across one rising edge so the assertions see it
   task automatic tx(input logic [10:0] id, input logic ext, input logic g);
      @(negedge ref_clk);
      tx_frame = '{id: id, ext: ext, rtr: 1'b0, dlc: 4'h8, data: PLD};
      tx_req = 1'b1;
      #1;
      `CHK(tx_grant, g)
      @(negedge ref_clk);
      tx_req = 1'b0;
   endtask

   task automatic t_powerup;
      int n;
      `CHK(gate, exp_gate(ST_INIT))
      wait_boot(7'h05, n);
      `CHK(n, INIT_CYC)
   endtask

   task automatic t_nmt;
      step(CMD_START, 8'h05, 1'b1, ST_OPER);
      step(CMD_START, 8'h05, 1'b1, ST_OPER);
      step(CMD_PREOP, 8'h06, 1'b0, ST_OPER);
      step(8'h03, 8'h00, 1'b0, ST_OPER);
      rx(ID_NMT, 1'b0, 1'b0, SV_NONE, 2'd0);
      `CHK(state_reg, ST_OPER)
      step(CMD_STOP, 8'h00, 1'b1, ST_STOP);
      rx(ID_SDO_RX + N, 1'b0, 1'b0, SV_NONE, 2'd0);
      rx(ID_RPDO1 + N, 1'b0, 1'b0, SV_NONE, 2'd0);
      tx(ID_NODEMON + N, 1'b0, 1'b0);
      tx(ID_EMCY + N, 1'b0, 1'b0);
      step(CMD_PREOP, 8'h00, 1'b1, ST_PREOP);
   endtask

   task automatic t_services;
      rx(ID_RPDO1 + N, 1'b0, 1'b0, SV_NONE, 2'd0);
      rx(ID_SDO_RX + N, 1'b0, 1'b1, SV_SDORX, 2'd0);
      rx(ID_SYNC, 1'b0, 1'b1, SV_SYNC, 2'd0);
      rx(11'h606, 1'b0, 1'b0, SV_NONE, 2'd0);
      rx(ID_SDO_RX + N, 1'b1, 1'b0, SV_NONE, 2'd0);
      tx(ID_SDO_TX + N, 1'b0, 1'b1);
      tx(ID_EMCY + N, 1'b0, 1'b1);
      tx(ID_TPDO1 + N, 1'b0, 1'b0);
      tx(ID_SDO_TX + N, 1'b1, 1'b0);
      step(CMD_START, 8'h00, 1'b1, ST_OPER);
      for (int k = 0; k < 4; k++)
      begin
         rx(ID_RPDO1 + 11'(k * 256) + N, 1'b0, 1'b1, SV_RPDO, 2'(k));
         tx(ID_TPDO1 + 11'(k * 256) + N, 1'b0, 1'b1);
      end
      rx(ID_NODEMON + N, 1'b0, 1'b1, SV_NODEM, 2'd0);
   endtask

   task automatic t_resets;
      int n;
      node_id_cfg = 7'h10;
      step(CMD_RST_COMM, 8'h05, 1'b1, ST_INIT);
      `CHK({node_reset_reg, comm_reset_reg}, 2'b01)
      wait_boot(7'h10, n);
      `CHK(n, INIT_CYC)
      node_id_cfg = 7'h00;
      step(CMD_RST_NODE, 8'h10, 1'b1, ST_INIT);
      `CHK({node_reset_reg, comm_reset_reg}, 2'b10)
      wait_boot(7'h01, n);
      `CHK(n, INIT_CYC)
   endtask

   initial
   begin
      srst = 1'b1;
      node_id_cfg = 7'h05;
      tx_req = 1'b0;
      tx_frame = '0;
      repeat (12) @(negedge ref_clk);
      srst = 1'b0;
      t_powerup;
      t_nmt;
      t_services;
      t_resets;
      close_out;
   end

   // the full run takes under a hundred cycles; this is far beyond it
   initial
   begin
      #50000;
      error_cnt++;
      close_out;
   end
endmodule // cnd_nmt_slave_tb
`default_nettype wire
